// file: hdl/tmr2rc_map.svh
// Summary of operation
// [R1] Split select clear: one 16-bit up-counter with automatic reload.
// [R2] 16-bit wrap from all ones loads reload pair and sets upper flag.
// [R3] With timer interrupt enabled, every 16-bit overflow requests interrupt.
// [R4] 16-bit mode: low-byte wrap also interrupts when lower enable set.
// [R5] Count clock: system, system/12, RTC/8 or comparator, slow ones synced.
// [R6] Split mode: each byte is an 8-bit counter reloading its own byte.
// [R7] Split mode: run bit gates only the high byte; low always counts.
// [R8] Per-byte select 1 uses system clock, else external field chooses source.
// [R9] Split mode: each byte wrap sets its own overflow flag.
// [R10] Split mode: high wrap interrupts; either wrap with lower enable set.
// [R11] Hardware never clears overflow flags; only software writes clear them.
// [R12] Software reads both flags to find the interrupt source.
// [R13] Capture mode is on while capture enable bit is one.
// [R14] Software should keep 16-bit mode while capture mode is used.
// [R15] Capture event on comparator rising edge or every 8 RTC cycles.
// [R16] Capture copies count into reload pair, sets upper flag, interrupts.
// [R17] Software should pick count clock much faster than capture rate.
// [R18] Low-byte wrap sets lower flag in every mode.
// [R19] Capture source bit 0 selects RTC/8, 1 selects comparator edges.
// [R20] Reserved external code gives no count pulses; the byte holds.
`ifndef TMR2RC_MAP_SVH
`define TMR2RC_MAP_SVH

// ---------------------------------------------------------------------------
// Clock source encodings and dividers
// ---------------------------------------------------------------------------
`define TMR2RC_XCLK_SYS12    2'h0
`define TMR2RC_XCLK_RTC8     2'h1
`define TMR2RC_XCLK_RSVD     2'h2
`define TMR2RC_XCLK_CMP      2'h3
`define TMR2RC_SYS_DIV_LAST  4'hb
`define TMR2RC_RTC_DIV_LAST  3'h7
`define TMR2RC_SYS_DIV_RST   4'h0
`define TMR2RC_SYS_DIV_STEP  4'h1
`define TMR2RC_RTC_DIV_RST   3'h0
`define TMR2RC_RTC_DIV_STEP  3'h1
`define TMR2RC_SYNC_RST      3'h0

// ---------------------------------------------------------------------------
// Byte values and reset values
// ---------------------------------------------------------------------------
`define TMR2RC_BYTE_MAX      8'hff
`define TMR2RC_BYTE_RST      8'h00
`define TMR2RC_CNT_STEP      8'h01
// Flag write layout: upper flag and lower flag positions within wdata.
`define TMR2RC_UPPER_FLAG_BIT 7
`define TMR2RC_LOWER_FLAG_BIT 6

`endif

// file: hdl/tmr2rc_pkg.sv
`default_nettype none
package tmr2rc_pkg;

  // Software-written control bits of the timer.
  typedef struct packed {
    logic       lower_overflow_irq_enable;
    logic       capture_mode_enable;
    logic       split_mode_select;
    logic       upper_run_control;
    logic [1:0] external_clock_select;
    logic       upper_clock_select;
    logic       lower_clock_select;
    logic       timer_two_irq_enable;
  } tmr2rc_ctrl_type;

  // One-cycle count and capture pulses, all in the system clock domain.
  typedef struct packed {
    logic sys12;
    logic rtc8;
    logic cmp_rise;
  } tmr2rc_tick_type;

  // Software byte write strobes and data.
  typedef struct packed {
    logic       count_low_wr;
    logic       count_high_wr;
    logic       reload_low_wr;
    logic       reload_high_wr;
    logic       flag_wr;
    logic [7:0] wdata;
  } tmr2rc_wr_type;

endpackage : tmr2rc_pkg
`default_nettype wire

// file: hdl/tmr2rc_src_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr2rc_map.svh"

module tmr2rc_src_gen (
  // Clock and reset.
  input  wire logic                  clk_sys_i,
  input  wire logic                  rstn_i,
  // Asynchronous sources.
  input  wire logic                  rtc_clk_i,
  input  wire logic                  cmp0_out_i,
  // Pulses toward the counter.
  output wire tmr2rc_pkg::tmr2rc_tick_type tick_o
);

  logic [3:0] sys_div;
  logic [2:0] rtc_div;
  logic [2:0] rtc_sync;
  logic [2:0] cmp_sync;

  // -------------------------------------------------------------------------
  // Synchronisers and edge detection
  // -------------------------------------------------------------------------
  // Bit 0 feeds only bit 1; edges are taken between bits 1 and 2.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rtc_sync <= `TMR2RC_SYNC_RST;
      cmp_sync <= `TMR2RC_SYNC_RST;
    end else begin
      rtc_sync <= {rtc_sync[1:0], rtc_clk_i};  // R5
      cmp_sync <= {cmp_sync[1:0], cmp0_out_i};  // R5
    end
  end

  wire rtc_rise = rtc_sync[1] & ~rtc_sync[2];
  wire cmp_rise = cmp_sync[1] & ~cmp_sync[2];

  // -------------------------------------------------------------------------
  // Dividers
  // -------------------------------------------------------------------------
  // Both dividers free-run so a source switch never waits on a stale phase.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_div <= `TMR2RC_SYS_DIV_RST;
      rtc_div <= `TMR2RC_RTC_DIV_RST;
    end else begin
      if (sys_div == `TMR2RC_SYS_DIV_LAST) begin
        sys_div <= `TMR2RC_SYS_DIV_RST;
      end else begin
        sys_div <= sys_div + `TMR2RC_SYS_DIV_STEP;
      end
      if (rtc_rise) begin
        rtc_div <= rtc_div + `TMR2RC_RTC_DIV_STEP;
      end
    end
  end

  // Pulses are combinational, one system clock wide.
  assign tick_o.sys12    = (sys_div == `TMR2RC_SYS_DIV_LAST);  // R5
  assign tick_o.rtc8     = rtc_rise & (rtc_div == `TMR2RC_RTC_DIV_LAST);
  assign tick_o.cmp_rise = cmp_rise;  // R15

endmodule : tmr2rc_src_gen
`default_nettype wire

// file: hdl/tmr2rc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr2rc_map.svh"

module tmr2rc_top (
  // Clock and reset.
  input  wire logic                   clk_sys_i,
  input  wire logic                   rstn_i,
  // Asynchronous clock sources.
  input  wire logic                   rtc_clk_i,
  input  wire logic                   cmp0_out_i,
  // Software control and writes.
  input  wire tmr2rc_pkg::tmr2rc_ctrl_type ctrl_i,
  input  wire tmr2rc_pkg::tmr2rc_wr_type   wr_i,
  // Timer state.
  output logic [7:0]                  count_low_byte_o,
  output logic [7:0]                  count_high_byte_o,
  output logic [7:0]                  reload_low_byte_o,
  output logic [7:0]                  reload_high_byte_o,
  output logic                        upper_overflow_flag_o,
  output logic                        lower_overflow_flag_o,
  // Interrupt request.
  output logic                        irq_o
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic       upper_overflow_flag;
  logic       lower_overflow_flag;

  tmr2rc_pkg::tmr2rc_tick_type tick;

  // -------------------------------------------------------------------------
  // Source pulses
  // -------------------------------------------------------------------------
  tmr2rc_src_gen u_src_gen (
    .clk_sys_i  (clk_sys_i),
    .rstn_i     (rstn_i),
    .rtc_clk_i  (rtc_clk_i),
    .cmp0_out_i (cmp0_out_i),
    .tick_o     (tick)
  );

  // -------------------------------------------------------------------------
  // Clock selection
  // -------------------------------------------------------------------------
  // The system clock selection counts on every cycle; the reserved code
  // yields no pulse so the byte simply holds.
  function automatic logic sel_tick(
    input logic                        use_sys,
    input logic [1:0]                  xclk,
    input tmr2rc_pkg::tmr2rc_tick_type t
  );
    logic r;
    r = 1'b0;
    if (use_sys) begin
      r = 1'b1;  // R8
    end else begin
      case (xclk)
        `TMR2RC_XCLK_SYS12: r = t.sys12;  // R8
        `TMR2RC_XCLK_RTC8:  r = t.rtc8;
        `TMR2RC_XCLK_CMP:   r = t.cmp_rise;
        default:            r = 1'b0;  // R20
      endcase
    end
    return r;
  endfunction : sel_tick

  // Byte increment with reload on wrap, shared by every counting path.
  function automatic logic [7:0] step_byte(
    input logic [7:0] cur,
    input logic [7:0] rld,
    input logic       reload
  );
    return reload ? rld : cur + `TMR2RC_CNT_STEP;
  endfunction : step_byte

  wire split   = ctrl_i.split_mode_select;
  wire capture = ctrl_i.capture_mode_enable;  // R13
  wire low_sel = sel_tick(ctrl_i.lower_clock_select,
                          ctrl_i.external_clock_select, tick);
  wire hi_sel  = sel_tick(ctrl_i.upper_clock_select,
                          ctrl_i.external_clock_select, tick);

  // -------------------------------------------------------------------------
  // Count enables and wrap detection
  // -------------------------------------------------------------------------
  // In 16-bit mode the lower select drives the whole counter and the run
  // bit gates it; in split mode the low byte ignores the run bit.
  wire low_tick = split ? low_sel                                    // R7
                        : low_sel & ctrl_i.upper_run_control;        // R1
  wire low_max  = (count_low_byte == `TMR2RC_BYTE_MAX);
  wire high_max = (count_high_byte == `TMR2RC_BYTE_MAX);
  wire hi_tick  = split ? hi_sel & ctrl_i.upper_run_control          // R7
                        : low_tick & low_max;                        // R1
  wire low_wrap = low_tick & low_max;                                // R18
  wire hi_wrap  = hi_tick & high_max;                                // R9

  // A 16-bit overflow reloads both bytes together; split mode reloads
  // each byte from its own reload byte.
  wire low_reload = split ? low_wrap : hi_wrap;                      // R2
  wire hi_reload  = hi_wrap;                                         // R6

  // Capture event source picked by the upper external select bit.
  wire cap_src   = ctrl_i.external_clock_select[1];
  wire cap_event = capture & (cap_src ? tick.cmp_rise                // R19
                                      : tick.rtc8);                  // R15

  // -------------------------------------------------------------------------
  // Next values
  // -------------------------------------------------------------------------
  logic [7:0] next_count_low_byte;
  logic [7:0] next_count_high_byte;
  logic [7:0] next_reload_low_byte;
  logic [7:0] next_reload_high_byte;
  logic       next_upper_overflow_flag;
  logic       next_lower_overflow_flag;

  // Software writes to the count win over a coincident count pulse.
  always_comb begin
    next_count_low_byte = count_low_byte;
    if (wr_i.count_low_wr) begin
      next_count_low_byte = wr_i.wdata;
    end else if (low_tick) begin
      next_count_low_byte = step_byte(count_low_byte, reload_low_byte,
                                      low_reload);  // R6
    end
  end

  always_comb begin
    next_count_high_byte = count_high_byte;
    if (wr_i.count_high_wr) begin
      next_count_high_byte = wr_i.wdata;
    end else if (hi_tick) begin
      next_count_high_byte = step_byte(count_high_byte, reload_high_byte,
                                       hi_reload);  // R2
    end
  end

  // A capture snapshots the count as it stands before this cycle's step,
  // and wins over a software reload write in the same cycle.
  always_comb begin
    next_reload_low_byte  = reload_low_byte;
    next_reload_high_byte = reload_high_byte;
    if (cap_event) begin
      next_reload_low_byte  = count_low_byte;   // R16
      next_reload_high_byte = count_high_byte;  // R16
    end else begin
      if (wr_i.reload_low_wr) begin
        next_reload_low_byte = wr_i.wdata;
      end
      if (wr_i.reload_high_wr) begin
        next_reload_high_byte = wr_i.wdata;
      end
    end
  end

  // Flags are written by software at bits 7 and 6; a hardware set in the
  // same cycle as a clearing write wins, so no event is lost.
  wire upper_set = hi_wrap | cap_event;  // R16
  wire lower_set = low_wrap;             // R18

  always_comb begin
    next_upper_overflow_flag = upper_overflow_flag;
    next_lower_overflow_flag = lower_overflow_flag;
    if (wr_i.flag_wr) begin
      next_upper_overflow_flag = wr_i.wdata[`TMR2RC_UPPER_FLAG_BIT];  // R11
      next_lower_overflow_flag = wr_i.wdata[`TMR2RC_LOWER_FLAG_BIT];  // R11
    end
    if (upper_set) begin
      next_upper_overflow_flag = 1'b1;  // R2
    end
    if (lower_set) begin
      next_lower_overflow_flag = 1'b1;  // R9
    end
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_low_byte   <= `TMR2RC_BYTE_RST;
      count_high_byte  <= `TMR2RC_BYTE_RST;
      reload_low_byte  <= `TMR2RC_BYTE_RST;
      reload_high_byte <= `TMR2RC_BYTE_RST;
    end else begin
      count_low_byte   <= next_count_low_byte;
      count_high_byte  <= next_count_high_byte;
      reload_low_byte  <= next_reload_low_byte;
      reload_high_byte <= next_reload_high_byte;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upper_overflow_flag <= 1'b0;
      lower_overflow_flag <= 1'b0;
    end else begin
      upper_overflow_flag <= next_upper_overflow_flag;  // R11
      lower_overflow_flag <= next_lower_overflow_flag;  // R11
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign count_low_byte_o      = count_low_byte;
  assign count_high_byte_o     = count_high_byte;
  assign reload_low_byte_o     = reload_low_byte;
  assign reload_high_byte_o    = reload_high_byte;
  assign upper_overflow_flag_o = upper_overflow_flag;
  assign lower_overflow_flag_o = lower_overflow_flag;

  // The request is a level from the flags, so it stays up until software
  // clears the flag that caused it; vectoring does not clear anything.
  wire lower_req = ctrl_i.lower_overflow_irq_enable & lower_overflow_flag;
  assign irq_o = ctrl_i.timer_two_irq_enable &
                 (upper_overflow_flag | lower_req);  // R3 R4 R10

endmodule : tmr2rc_top
`default_nettype wire

// file: verification/tmr2rc_props.sv
`timescale 1ns/1ps
`default_nettype none
module tmr2rc_props (
  // Clock and reset.
  input wire logic                        clk_sys_i,
  input wire logic                        rstn_i,
  // Control and writes.
  input wire tmr2rc_pkg::tmr2rc_ctrl_type ctrl_i,
  input wire tmr2rc_pkg::tmr2rc_wr_type   wr_i,
  // Timer state.
  input wire logic [7:0]                  count_low_byte_o,
  input wire logic [7:0]                  count_high_byte_o,
  input wire logic [7:0]                  reload_low_byte_o,
  input wire logic [7:0]                  reload_high_byte_o,
  input wire logic                        upper_overflow_flag_o,
  input wire logic                        lower_overflow_flag_o,
  input wire logic                        irq_o
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  // Cycles without software writes, so hardware steps are not masked.
  wire logic        no_wr = ~|wr_i[12:8];
  wire logic [15:0] cnt   = {count_high_byte_o, count_low_byte_o};
  wire logic [15:0] rld   = {reload_high_byte_o, reload_low_byte_o};
  wire logic [7:0]  lo    = count_low_byte_o;
  wire logic        m16   = no_wr & !ctrl_i.split_mode_select &
                            !ctrl_i.capture_mode_enable;
  wire logic        sys16 = m16 & ctrl_i.lower_clock_select &
                            ctrl_i.upper_run_control;
  wire logic        spl   = no_wr & ctrl_i.split_mode_select &
                            !ctrl_i.capture_mode_enable;
  wire logic        lsys  = spl & ctrl_i.lower_clock_select;
  // Interrupt line follows the flags and both enables at once.
  AST_IRQ: assert property (
    irq_o == (ctrl_i.timer_two_irq_enable & (upper_overflow_flag_o |
    ctrl_i.lower_overflow_irq_enable & lower_overflow_flag_o)))
    else $error("irq level does not match flags and enables");
  AST_WRAP16: assert property (
    sys16 && cnt == 16'hffff |=> cnt == $past(rld) && upper_overflow_flag_o)
    else $error("16-bit wrap did not reload and flag");
  AST_INC16: assert property (
    sys16 && cnt != 16'hffff |=> cnt == $past(cnt) + 16'h0001)
    else $error("16-bit counter did not step by one");
  AST_LOW_FREE: assert property (
    lsys && lo != 8'hff |=> lo == $past(lo) + 8'h01)
    else $error("split low byte did not count");
  AST_LOW_RELOAD: assert property (
    lsys && lo == 8'hff |=> lo == $past(reload_low_byte_o) &&
    lower_overflow_flag_o)
    else $error("split low byte did not reload and flag");
  AST_HIGH_GATE: assert property (
    spl && !ctrl_i.upper_run_control |=> $stable(count_high_byte_o))
    else $error("split high byte moved while stopped");
  AST_RSVD: assert property (
    m16 && !ctrl_i.lower_clock_select &&
    ctrl_i.external_clock_select == 2'h2 |=> $stable(cnt))
    else $error("reserved source produced a count");
  AST_LOW_FLAG: assert property (
    $rose(lower_overflow_flag_o) |->
    $past(lo) == 8'hff || $past(wr_i.flag_wr))
    else $error("lower flag set without a low byte wrap");
  AST_STICKY: assert property (
    $fell(upper_overflow_flag_o) || $fell(lower_overflow_flag_o) |->
    $past(wr_i.flag_wr))
    else $error("overflow flag cleared by hardware");
  // Main scenarios reached.
  cover property (sys16 && cnt == 16'hffff);
  cover property (lsys && !ctrl_i.upper_run_control && lo == 8'hff);
  cover property (ctrl_i.capture_mode_enable && $changed(rld));
endmodule : tmr2rc_props
bind tmr2rc_top tmr2rc_props u_props (.clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i), .ctrl_i(ctrl_i), .wr_i(wr_i),
  .count_low_byte_o(count_low_byte_o), .count_high_byte_o(count_high_byte_o),
  .reload_low_byte_o(reload_low_byte_o),
  .reload_high_byte_o(reload_high_byte_o),
  .upper_overflow_flag_o(upper_overflow_flag_o),
  .lower_overflow_flag_o(lower_overflow_flag_o), .irq_o(irq_o));
`default_nettype wire

// file: verification/tmr2rc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmr2rc_src_model (
  // Slow sources toward the timer.
  output var logic rtc_clk_o,
  output var logic cmp0_o
);
  // Both rest low; the oscillator stands still between bursts.
  initial begin
    rtc_clk_o = 1'b0;
    cmp0_o = 1'b0;
  end
  // Called 1 ns after a falling edge; a 40 ns period keeps every edge
  // clear of the rising edge, where the synchroniser samples.
  task automatic rtc_edges(input int n);
    repeat (n) begin
      #20 rtc_clk_o = 1'b1;
      #20 rtc_clk_o = 1'b0;
    end
  endtask : rtc_edges
  // Held long enough to cross the two-stage synchroniser.
  task automatic cmp_edge();
    #50 cmp0_o = 1'b1;
    #100 cmp0_o = 1'b0;
  endtask : cmp_edge
endmodule : tmr2rc_src_model
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                        clk_sys_i;
  logic                        rstn_i;
  logic                        rtc_clk;
  logic                        cmp0_out;
  tmr2rc_pkg::tmr2rc_ctrl_type ctrl_i;
  tmr2rc_pkg::tmr2rc_wr_type   wr_i;
  logic [7:0]                  lo, hi, rl, rh;
  logic                        uf, lf, irq;
  int                          failures;
  int                          n_tests;
  wire logic [15:0]            cnt = {hi, lo};
  wire logic [15:0]            rld = {rh, rl};
  wire logic [15:0]            st  = {13'h0, uf, lf, irq};
  tmr2rc_top u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .rtc_clk_i(rtc_clk), .cmp0_out_i(cmp0_out), .ctrl_i(ctrl_i),
    .wr_i(wr_i), .count_low_byte_o(lo), .count_high_byte_o(hi),
    .reload_low_byte_o(rl), .reload_high_byte_o(rh),
    .upper_overflow_flag_o(uf), .lower_overflow_flag_o(lf), .irq_o(irq));
  tmr2rc_src_model u_src (.rtc_clk_o(rtc_clk), .cmp0_o(cmp0_out));
  // 125 MHz system clock.
  always #4 clk_sys_i = ~clk_sys_i;
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  // Control is {low irq en, capture, split, run, xclk, hi sel, lo sel, irq}.
  task automatic cfg(input logic [8:0] c);
    @(negedge clk_sys_i);
    ctrl_i = tmr2rc_pkg::tmr2rc_ctrl_type'(c);
    #1;
  endtask : cfg
  // Run high across exactly one rising edge gives one count step.
  task automatic step(input logic [8:0] c);
    cfg(c | 9'h020);
    cfg(c);
  endtask : step
  // Strobes are {low, high, reload low, reload high, flags}.
  task automatic wr(input logic [4:0] s, input logic [7:0] d);
    @(negedge clk_sys_i);
    wr_i = tmr2rc_pkg::tmr2rc_wr_type'({s, d});
    @(negedge clk_sys_i);
    wr_i = '0;
  endtask : wr
  // Stopped timer first, so no count pulse races the writes.
  task automatic set16(input logic [15:0] c, input logic [15:0] r);
    cfg(9'h000);
    wr(5'h10, c[7:0]);
    wr(5'h08, c[15:8]);
    wr(5'h04, r[7:0]);
    wr(5'h02, r[15:8]);
    wr(5'h01, 8'h00);
    #1;
  endtask : set16
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys_i);
    #1;
  endtask : wait_n
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_wrap16();
    set16(16'hffff, 16'habcd);
    step(9'h003);
    chk(cnt, 16'habcd);
    chk(st, 16'h0007);
    wr(5'h01, 8'h00);
    #1;
    chk(st, 16'h0000);
    set16(16'h00ff, 16'h0000);
    step(9'h103);
    chk(cnt, 16'h0100);
    chk(st, 16'h0003);
    cfg(9'h003);
    chk(st, 16'h0002);
  endtask : t_wrap16
  task automatic t_split();
    set16(16'hfffe, 16'h2010);
    cfg(9'h047);
    wait_n(2);
    chk(cnt, 16'hff10);
    chk(st, 16'h0002);
    cfg(9'h147);
    chk(st, 16'h0003);
    chk({15'h0, uf}, 16'h0000);
    step(9'h147);
    chk({8'h00, hi}, 16'h0020);
    chk(st, 16'h0007);
  endtask : t_split
  // Dividers free-run, so whole multiples of their period give exact counts.
  task automatic t_src();
    set16(16'h0000, 16'h0000);
    cfg(9'h020);
    wait_n(47);
    cfg(9'h000);
    chk(cnt, 16'h0004);
    set16(16'h0000, 16'h0000);
    cfg(9'h030);
    wait_n(47);
    cfg(9'h000);
    chk(cnt, 16'h0000);
    set16(16'h0000, 16'h0000);
    cfg(9'h028);
    u_src.rtc_edges(16);
    wait_n(6);
    cfg(9'h000);
    chk(cnt, 16'h0002);
    set16(16'h0000, 16'h0000);
    cfg(9'h038);
    repeat (3) u_src.cmp_edge();
    wait_n(6);
    cfg(9'h000);
    chk(cnt, 16'h0003);
  endtask : t_src
  // Counter stopped, so every capture must copy the same value.
  task automatic t_cap();
    set16(16'h1234, 16'h0000);
    cfg(9'h09b);
    u_src.cmp_edge();
    wait_n(6);
    chk(rld, 16'h1234);
    chk(st, 16'h0005);
    set16(16'h5678, 16'h0000);
    cfg(9'h08b);
    u_src.rtc_edges(10);
    wait_n(6);
    chk(rld, 16'h5678);
  endtask : t_cap
  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    rstn_i = 1'b0;
    ctrl_i = '0;
    wr_i = '0;
    failures = 0;
    n_tests = 0;
    repeat (10) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    chk(cnt | rld | st, 16'h0000);
    t_wrap16();
    t_split();
    t_src();
    t_cap();
    end_of_test();
  end
  // The whole run needs well under 200 us; a hang ends here instead.
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
